// ---- pkg/trs_pkg.sv ----
// Purpose: Shared constants for the torque reference scaling and offset block
// Assumes: 32-bit classic Wishbone register access, 250 MHz core clock
// Notes:   Offsets are byte addresses of aligned words
package trs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] TRS_OFF_METHOD  = 8'h00; // Method-select parameter
  localparam logic [7:0] TRS_OFF_GAIN    = 8'h04; // Torque input gain
  localparam logic [7:0] TRS_OFF_OFFSET  = 8'h08; // Offset correction steps
  localparam logic [7:0] TRS_OFF_CTRL    = 8'h0C; // Utility commands and switches
  localparam logic [7:0] TRS_OFF_STATUS  = 8'h10; // Live block state
  localparam logic [7:0] TRS_OFF_REFIN   = 8'h14; // Reference sample, mV
  localparam logic [7:0] TRS_OFF_TORQUE  = 8'h18; // Commanded torque
  localparam logic [7:0] TRS_OFF_IRQ_ST  = 8'h1C; // Sticky event status
  localparam logic [7:0] TRS_OFF_IRQ_EN  = 8'h20; // Event enable
  localparam logic [7:0] TRS_OFF_IRQ_CLR = 8'h24; // Write-one-to-clear

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TRS_CTRL_START   = 0; // Start automatic offset
  localparam int TRS_CTRL_CANCEL  = 1; // Cancel from execution display
  localparam int TRS_CTRL_WR_OK   = 2; // Write-permitted setting
  localparam int TRS_CTRL_PLOOP   = 3; // Host position loop closed
  localparam int TRS_CTRL_PINIT   = 4; // Parameter initialisation
  localparam int TRS_CTRL_RESTART = 5; // Restart: latch method
  localparam int TRS_EV_DONE      = 0; // Auto offset completed
  localparam int TRS_EV_REFUSED   = 1; // Auto offset refused
  localparam int TRS_EV_OVL_HIGH  = 2; // High-load overload alarm
  localparam int TRS_EV_OVL_LOW   = 3; // Low-load overload alarm
  localparam int TRS_EV_CANCEL    = 4; // Cancelled to menu
  localparam int TRS_NUM_EV       = 5;

  // ----------------------------------------------------------------
  // Values and limits
  // ----------------------------------------------------------------
  localparam logic [3:0]  TRS_METHOD_TORQUE = 4'h2;   // Control digit for torque
  localparam logic [15:0] TRS_METHOD_RST    = 16'h0000;
  localparam logic [6:0]  TRS_GAIN_MIN      = 7'h0A;  // 1.0 V
  localparam logic [6:0]  TRS_GAIN_MAX      = 7'h64;  // 10.0 V
  localparam logic [6:0]  TRS_GAIN_RST      = 7'h1E;  // 3.0 V
  localparam logic [7:0]  TRS_OFS_MAX       = 8'h7F;  // +127 steps
  localparam logic [7:0]  TRS_OFS_MIN       = 8'h81;  // -127 steps
  localparam int          TRS_OFS_STEP_UV   = 15000;  // 15.0 mV per step
  localparam int          TRS_GAIN_UNIT_MV  = 100;    // 0.1 V per gain unit
  localparam int          TRS_RATED_PERMIL  = 1000;   // Rated torque in 0.1 %

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int TRS_CLK_MHZ      = 250;
  localparam int TRS_MEAS_US      = 10;   // Offset averaging window
  localparam int TRS_MEAS_CYC     = TRS_MEAS_US * TRS_CLK_MHZ;
  localparam int TRS_OVL_HIGH_PM  = 3000; // High-load threshold, 0.1 %
  localparam int TRS_OVL_LOW_PM   = 1500; // Low-load threshold, 0.1 %
  localparam int TRS_OVL_HIGH_MS  = 1;
  localparam int TRS_OVL_LOW_MS   = 100;
  localparam int TRS_OVL_HIGH_CYC = TRS_OVL_HIGH_MS * TRS_CLK_MHZ * 1000;
  localparam int TRS_OVL_LOW_CYC  = TRS_OVL_LOW_MS * TRS_CLK_MHZ * 1000;

  // ----------------------------------------------------------------
  // Utility sequence states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TRS_IDLE,
    TRS_MEASURE,
    TRS_STORE
  } trs_state_t;

endpackage

// ---- src/trs_ovl_timer.sv ----
// Purpose: Persistence timer raising an alarm when a level stays high
// Assumes: Single core clock, asynchronous active-high reset
// Notes:   Alarm is a one-cycle pulse; count restarts when level drops
`timescale 1ns/1ns
module trs_ovl_timer #(
  parameter int LIMIT = 1000
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Condition and alarm
  input  wire logic over,
  output logic      alarm
);

  logic [31:0] cnt_r; // Persistence count

  // ----------------------------------------------------------------
  // Count while over, pulse once at the limit
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 32'h0000_0000;
      alarm <= 1'b0;
    end else if (!over) begin
      cnt_r <= 32'h0000_0000;
      alarm <= 1'b0;
    end else begin
      alarm <= (cnt_r == 32'(LIMIT - 1));
      if (cnt_r != 32'(LIMIT)) cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

endmodule // trs_ovl_timer

// ---- src/trs_top.sv ----
// Purpose: Torque reference scaling with automatic and manual offset correction
// Assumes: Reference arrives as a signed mV sample from an external converter
// Notes:   Registers on classic Wishbone; one level interrupt output
// Behaviour
// (R1) Torque mode when method digit is 2, after restart
// (R2) Torque follows reference voltage sign and size
// (R3) Gain 10..100 sets volts for rated torque
// (R4) Over-rated accepted; persistent excess raises overload alarms
// (R5) Offset correction -127..+127 steps of 15 mV
// (R6) Offset set automatically or by manual entry
// (R7) Auto function measures offset, stores and keeps it
// (R8) Parameter initialisation leaves offset correction intact
// (R9) Auto only when writes permitted and motor off
// (R10) Host gives servo off and 0 V first
// (R11) Processing status while measuring, then blocked state
// (R12) No auto offset with host position loop closed
// (R13) Offset removed before gain scaling
`timescale 1ns/1ns
module trs_top #(
  parameter int OVL_HIGH_CYC = trs_pkg::TRS_OVL_HIGH_CYC,
  parameter int OVL_LOW_CYC  = trs_pkg::TRS_OVL_LOW_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Reference sample and servo-on pin
  input  wire logic [15:0] ref_mv,
  input  wire logic        servo_on_n,
  // Motor side
  output logic             torque_mode,
  output logic [15:0]      torque_cmd,
  output logic             processing,
  output logic             power_blocked_state,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] method_select_param_r;  // Stored method parameter
  logic        torque_mode_r;           // Active control mode
  logic [6:0]  torque_input_gain_param_r; // Gain, 0.1 V units
  logic [7:0]  offset_r;                // Correction steps, signed
  logic        write_ok_r;              // Write-permitted setting
  logic        ploop_r;                 // Host position loop closed
  logic [trs_pkg::TRS_NUM_EV-1:0] ev_st_r; // Sticky events
  logic [trs_pkg::TRS_NUM_EV-1:0] ev_en_r; // Event enables
  logic [trs_pkg::TRS_NUM_EV-1:0] ev_set;  // Event pulses
  logic [trs_pkg::TRS_NUM_EV-1:0] ev_clr;  // Clear requests
  logic [2:0]  son_sync_r;              // Servo-on pin synchroniser
  logic        servo_off_r;             // Filtered servo off level
  trs_pkg::trs_state_t state_r;         // Utility sequence
  logic [31:0] meas_cnt_r;              // Averaging sample count
  logic signed [47:0] meas_acc_r;       // Summed reference, mV
  logic signed [31:0] corr_mv;          // Offset-corrected reference
  logic signed [47:0] scaled;           // Torque before clamp
  logic signed [31:0] avg_mv;           // Measured offset
  logic signed [31:0] steps;            // Offset in steps
  logic [15:0] torque_r;                // Registered torque command
  logic        wr_stb;                  // Bus write strobe
  logic        start_cmd;               // Start command pulse
  logic        cancel_cmd;              // Cancel command pulse
  logic        allow_auto;              // Start preconditions met
  logic        ovl_hi_alarm;            // High-load alarm pulse
  logic        ovl_lo_alarm;            // Low-load alarm pulse
  logic [31:0] abs_torque;              // Torque magnitude

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign wr_stb     = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign start_cmd  = wr_stb && (wb_adr_i == trs_pkg::TRS_OFF_CTRL)
                      && wb_dat_i[trs_pkg::TRS_CTRL_START];
  assign cancel_cmd = wr_stb && (wb_adr_i == trs_pkg::TRS_OFF_CTRL)
                      && wb_dat_i[trs_pkg::TRS_CTRL_CANCEL];

  // Ack one cycle after request, dropped the cycle after
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) wb_ack_o <= 1'b0;
    else       wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  // Read data register; unmapped reads return zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      case (wb_adr_i)
        trs_pkg::TRS_OFF_METHOD: wb_dat_o <= {16'h0000, method_select_param_r};
        trs_pkg::TRS_OFF_GAIN:   wb_dat_o <= {25'h0000000, torque_input_gain_param_r};
        trs_pkg::TRS_OFF_OFFSET: wb_dat_o <= {{24{offset_r[7]}}, offset_r};
        trs_pkg::TRS_OFF_CTRL:   wb_dat_o <= {28'h0000000, ploop_r, write_ok_r, 2'h0};
        trs_pkg::TRS_OFF_STATUS: wb_dat_o <= {28'h0000000, servo_off_r, torque_mode_r,
                                              power_blocked_state, processing};
        trs_pkg::TRS_OFF_REFIN:  wb_dat_o <= {{16{ref_mv[15]}}, ref_mv};
        trs_pkg::TRS_OFF_TORQUE: wb_dat_o <= {{16{torque_r[15]}}, torque_r};
        trs_pkg::TRS_OFF_IRQ_ST: wb_dat_o <= {27'h0000000, ev_st_r};
        trs_pkg::TRS_OFF_IRQ_EN: wb_dat_o <= {27'h0000000, ev_en_r};
        default:                 wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Parameters written by software
  // ----------------------------------------------------------------
  // Method parameter and restart latch
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      method_select_param_r <= trs_pkg::TRS_METHOD_RST;
      torque_mode_r         <= 1'b0;
    end else begin
      if (wr_stb && wb_adr_i == trs_pkg::TRS_OFF_METHOD)
        method_select_param_r <= wb_dat_i[15:0];
      // New method takes effect only on restart
      if (wr_stb && wb_adr_i == trs_pkg::TRS_OFF_CTRL
          && wb_dat_i[trs_pkg::TRS_CTRL_RESTART])
        torque_mode_r <= (method_select_param_r[7:4] == trs_pkg::TRS_METHOD_TORQUE); // R1
    end
  end

  // Gain applies at once; out-of-range writes are clamped
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      torque_input_gain_param_r <= trs_pkg::TRS_GAIN_RST;
    end else if (wr_stb && wb_adr_i == trs_pkg::TRS_OFF_GAIN) begin
      if (wb_dat_i[6:0] < trs_pkg::TRS_GAIN_MIN || wb_dat_i[31:7] != 25'h0000000)
        torque_input_gain_param_r <= (wb_dat_i[31:7] != 25'h0000000) ?
                                     trs_pkg::TRS_GAIN_MAX : trs_pkg::TRS_GAIN_MIN; // R3
      else if (wb_dat_i[6:0] > trs_pkg::TRS_GAIN_MAX)
        torque_input_gain_param_r <= trs_pkg::TRS_GAIN_MAX; // R3
      else
        torque_input_gain_param_r <= wb_dat_i[6:0]; // R3
    end else if (wr_stb && wb_adr_i == trs_pkg::TRS_OFF_CTRL
                 && wb_dat_i[trs_pkg::TRS_CTRL_PINIT]) begin
      torque_input_gain_param_r <= trs_pkg::TRS_GAIN_RST;
    end
  end

  // Control switches
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      write_ok_r <= 1'b0;
      ploop_r    <= 1'b0;
    end else if (wr_stb && wb_adr_i == trs_pkg::TRS_OFF_CTRL) begin
      write_ok_r <= wb_dat_i[trs_pkg::TRS_CTRL_WR_OK];
      ploop_r    <= wb_dat_i[trs_pkg::TRS_CTRL_PLOOP];
    end
  end

  // ----------------------------------------------------------------
  // Servo-on pin synchroniser
  // ----------------------------------------------------------------
  // Level changes once second and third stages agree
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      son_sync_r  <= 3'h7;
      servo_off_r <= 1'b1;
    end else begin
      son_sync_r <= {son_sync_r[1:0], servo_on_n};
      if (son_sync_r[1] == son_sync_r[2]) servo_off_r <= son_sync_r[2];
    end
  end

  // ----------------------------------------------------------------
  // Automatic offset sequence
  // ----------------------------------------------------------------
  assign allow_auto = write_ok_r && servo_off_r && !ploop_r; // R9 R12

  // Averaged offset in mV and truncated to whole steps
  assign avg_mv = 32'(meas_acc_r / 48'(trs_pkg::TRS_MEAS_CYC));
  assign steps  = 32'((64'(avg_mv) * 64'sd1000) / 64'(trs_pkg::TRS_OFS_STEP_UV));

  // Idle, measure, store; processing shown until stored
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r    <= trs_pkg::TRS_IDLE;
      meas_cnt_r <= 32'h0000_0000;
      meas_acc_r <= 48'h0000_0000_0000;
    end else begin
      case (state_r)
        trs_pkg::TRS_IDLE: begin
          meas_cnt_r <= 32'h0000_0000;
          meas_acc_r <= 48'h0000_0000_0000;
          if (start_cmd && !cancel_cmd && allow_auto)
            state_r <= trs_pkg::TRS_MEASURE; // R11
        end
        trs_pkg::TRS_MEASURE: begin
          // Host holds 0 V and servo off here
          meas_acc_r <= meas_acc_r + 48'(signed'(ref_mv)); // R7 R10
          meas_cnt_r <= meas_cnt_r + 32'h0000_0001;
          if (meas_cnt_r == 32'(trs_pkg::TRS_MEAS_CYC - 1))
            state_r <= trs_pkg::TRS_STORE;
        end
        trs_pkg::TRS_STORE: state_r <= trs_pkg::TRS_IDLE; // R11
        default:            state_r <= trs_pkg::TRS_IDLE;
      endcase
    end
  end

  assign processing          = (state_r != trs_pkg::TRS_IDLE); // R11
  assign power_blocked_state = servo_off_r && !processing;     // R11

  // Offset correction: auto store or manual write; initialisation ignored
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      offset_r <= 8'h00;
    end else if (state_r == trs_pkg::TRS_STORE) begin
      if (steps > 32'sd127)       offset_r <= trs_pkg::TRS_OFS_MAX; // R5
      else if (steps < -32'sd127) offset_r <= trs_pkg::TRS_OFS_MIN; // R5
      else                        offset_r <= steps[7:0];          // R7
    end else if (wr_stb && wb_adr_i == trs_pkg::TRS_OFF_OFFSET && write_ok_r) begin
      if (wb_dat_i[7:0] == 8'h80) offset_r <= trs_pkg::TRS_OFS_MIN; // R5
      else                        offset_r <= wb_dat_i[7:0];       // R6
    end
    // Parameter initialisation has no branch here // R8
  end

  // ----------------------------------------------------------------
  // Torque scaling
  // ----------------------------------------------------------------
  // Subtract offset steps before gain scaling
  assign corr_mv = 32'(signed'(ref_mv))
                   - 32'((32'(signed'(offset_r)) * 32'(trs_pkg::TRS_OFS_STEP_UV)) / 1000); // R13
  // Torque in 0.1 % of rated: mV * 1000 / (gain * 100 mV)
  assign scaled  = (48'(corr_mv) * 48'(trs_pkg::TRS_RATED_PERMIL))
                   / 48'(signed'(32'(torque_input_gain_param_r))
                         * trs_pkg::TRS_GAIN_UNIT_MV); // R2 R3

  // Register torque; no upper clamp below 16-bit range
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      torque_r <= 16'h0000;
    end else if (!torque_mode_r || servo_off_r || processing) begin
      torque_r <= 16'h0000;
    end else if (scaled > 48'sd32767) begin
      torque_r <= 16'h7FFF; // R4
    end else if (scaled < -48'sd32767) begin
      torque_r <= 16'h8001; // R4
    end else begin
      torque_r <= scaled[15:0]; // R2
    end
  end

  assign torque_cmd  = torque_r;
  assign torque_mode = torque_mode_r;
  assign abs_torque  = torque_r[15] ? 32'(-signed'(torque_r)) : 32'(torque_r);

  // ----------------------------------------------------------------
  // Overload timers
  // ----------------------------------------------------------------
  trs_ovl_timer #(.LIMIT(OVL_HIGH_CYC)) u_ovl_high (
    .core_clk (core_clk),
    .reset    (reset),
    .over     (abs_torque > 32'(trs_pkg::TRS_OVL_HIGH_PM)), // R4
    .alarm    (ovl_hi_alarm)
  );

  trs_ovl_timer #(.LIMIT(OVL_LOW_CYC)) u_ovl_low (
    .core_clk (core_clk),
    .reset    (reset),
    .over     (abs_torque > 32'(trs_pkg::TRS_OVL_LOW_PM)), // R4
    .alarm    (ovl_lo_alarm)
  );

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign ev_set[trs_pkg::TRS_EV_DONE]     = (state_r == trs_pkg::TRS_STORE);
  assign ev_set[trs_pkg::TRS_EV_REFUSED]  = start_cmd && !cancel_cmd && !allow_auto
                                            && (state_r == trs_pkg::TRS_IDLE); // R9
  assign ev_set[trs_pkg::TRS_EV_OVL_HIGH] = ovl_hi_alarm; // R4
  assign ev_set[trs_pkg::TRS_EV_OVL_LOW]  = ovl_lo_alarm; // R4
  assign ev_set[trs_pkg::TRS_EV_CANCEL]   = cancel_cmd && (state_r == trs_pkg::TRS_IDLE); // R11
  assign ev_clr = (wr_stb && wb_adr_i == trs_pkg::TRS_OFF_IRQ_CLR) ?
                  wb_dat_i[trs_pkg::TRS_NUM_EV-1:0] : '0;

  // Sticky status, set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < trs_pkg::TRS_NUM_EV; gi++) begin : g_ev
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset)           ev_st_r[gi] <= 1'b0;
        else if (ev_set[gi]) ev_st_r[gi] <= 1'b1;
        else if (ev_clr[gi]) ev_st_r[gi] <= 1'b0;
      end
    end
  endgenerate

  // Enable register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) ev_en_r <= '0;
    else if (wr_stb && wb_adr_i == trs_pkg::TRS_OFF_IRQ_EN)
      ev_en_r <= wb_dat_i[trs_pkg::TRS_NUM_EV-1:0];
  end

  assign irq = |(ev_st_r & ev_en_r);

endmodule // trs_top

// ---- sim/trs_top_monitor.sv ----
// Purpose: Port checker for trs_top
// Assumes: One clock, classic Wishbone slave
// Notes:   Bound into every trs_top
`timescale 1ns/1ns
module trs_top_chk #(
  parameter int OVL_HIGH_CYC = 20,
  parameter int OVL_LOW_CYC  = 50
) (
  // Clock, reset, bus
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Motor side
  input wire logic        servo_on_n,
  input wire logic        torque_mode,
  input wire logic [15:0] torque_cmd,
  input wire logic        processing,
  input wire logic        power_blocked_state
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Cycles spent processing
  logic [11:0] proc_cnt_r;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) proc_cnt_r <= 12'h000;
    else if (processing) proc_cnt_r <= proc_cnt_r + 12'h001;
    else proc_cnt_r <= 12'h000;
  end
  property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("late ack");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_dat_hold; !(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_tq_mode; !torque_mode && !$past(torque_mode) |-> torque_cmd == 16'h0000;
  endproperty
  a_tq_mode: assert property (p_tq_mode) else $error("torque outside mode");
  property p_tq_proc; processing && $past(processing) |-> torque_cmd == 16'h0000;
  endproperty
  a_tq_proc: assert property (p_tq_proc) else $error("torque while measuring");
  property p_excl; processing |-> !power_blocked_state; endproperty
  a_excl: assert property (p_excl) else $error("blocked while measuring");
  property p_proc_len; $fell(processing) |-> proc_cnt_r >= 12'h9C4 && proc_cnt_r <= 12'h9C5;
  endproperty
  a_proc_len: assert property (p_proc_len) else $error("measure length");
  property p_bb; $fell(processing) && servo_on_n |-> ##[0:1] power_blocked_state; endproperty
  a_bb: assert property (p_bb) else $error("no blocked state after");
endmodule // trs_top_chk
bind trs_top trs_top_chk #(.OVL_HIGH_CYC(OVL_HIGH_CYC), .OVL_LOW_CYC(OVL_LOW_CYC)) u_chk (
  .core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .servo_on_n(servo_on_n),
  .torque_mode(torque_mode), .torque_cmd(torque_cmd), .processing(processing),
  .power_blocked_state(power_blocked_state));

// ---- sim/trs_host_model.sv ----
// Purpose: Host controller driving reference and servo-on pin
// Assumes: Reference steps at once or slews 64 mV a cycle
// Notes:   Servo off and 0 V while in reset
`timescale 1ns/1ns
module trs_host_model (
  // Clock, reset and bench commands
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic [15:0] tgt_mv,
  input wire logic        srv_on,
  input wire logic        slow,
  // Pins toward the block
  output logic [15:0]     ref_mv,
  output logic            servo_on_n
);
  logic signed [16:0] diff;
  assign diff = $signed({tgt_mv[15], tgt_mv}) - $signed({ref_mv[15], ref_mv});
  // Analog reference output
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) ref_mv <= 16'h0000;
    else if (!slow || (diff < 64 && diff > -64)) ref_mv <= tgt_mv;
    else if (diff > 0) ref_mv <= ref_mv + 16'h0040;
    else ref_mv <= ref_mv - 16'h0040;
  end
  // Servo-on pin, low means on
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) servo_on_n <= 1'b1;
    else servo_on_n <= !srv_on;
  end
endmodule // trs_host_model

// ---- sim/test_trs_top.sv ----
// Purpose: Self-checking bench for trs_top
// Assumes: Inputs driven on rising edges
// Notes:   Overload timers shortened to 20 and 50 cycles
`timescale 1ns/1ns
module test_trs_top;
  logic        core_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, servo_on_n;
  logic        torque_mode, processing, power_blocked_state, irq, srv_on, slow;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] ref_mv, torque_cmd, tgt_mv;
  int          err_total, checked, n;
  // Refused starts and torque cases
  logic [31:0] rf_ctl [3] = '{32'h01, 32'h0D, 32'h05};
  logic        rf_srv [3] = '{1'b0, 1'b0, 1'b1};
  logic [31:0] tq_gw  [4] = '{32'h1E, 32'h1E, 32'h05, 32'hC8};
  logic [31:0] tq_gr  [4] = '{32'h1E, 32'h1E, 32'h0A, 32'h64};
  logic [15:0] tq_ref [4] = '{16'h0BE5, 16'hFA51, 16'h0415, 16'hD91D};
  logic [15:0] tq_exp [4] = '{16'h03E8, 16'hFE0C, 16'h03E8, 16'hFC18};
  trs_top #(.OVL_HIGH_CYC(20), .OVL_LOW_CYC(50)) i_trs_top (.core_clk(core_clk),
    .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ref_mv(ref_mv), .servo_on_n(servo_on_n),
    .torque_mode(torque_mode), .torque_cmd(torque_cmd), .processing(processing),
    .power_blocked_state(power_blocked_state), .irq(irq));
  trs_host_model i_trs_host_model (.core_clk(core_clk), .reset(reset), .tgt_mv(tgt_mv),
    .srv_on(srv_on), .slow(slow), .ref_mv(ref_mv), .servo_on_n(servo_on_n));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Verdict and end of run
  task automatic test_done();
    $display("compares %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One classic Wishbone cycle, held until ack
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n >= 50) cmp(32'h0, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    cmp(q, e);
  endtask
  task automatic host(input logic [15:0] mv, input logic on);
    tgt_mv <= mv;
    srv_on <= on;
    repeat (250) @(posedge core_clk);
  endtask
  initial begin
    #240000;
    err_total++;
    test_done();
  end
  initial begin
    {reset, wb_cyc_i, wb_stb_i, wb_we_i, srv_on, slow} = 6'h20;
    {wb_adr_i, wb_dat_i, tgt_mv} = 56'h0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rdc(8'h04, 32'h1E);
    rdc(8'h08, 32'h0);
    rdc(8'h10, 32'h0A);
    rdc(8'h30, 32'h0);
    wr(8'h00, 32'h20);
    cmp({31'h0, torque_mode}, 32'h0);
    wr(8'h0C, 32'h24);
    rdc(8'h10, 32'h0E);
    wr(8'h20, 32'h1F);
    for (int i = 0; i < 3; i++) begin
      host(16'h0, rf_srv[i]);
      wr(8'h0C, rf_ctl[i] & 32'h0C);
      wr(8'h0C, rf_ctl[i]);
      rdc(8'h1C, 32'h02);
      cmp({31'h0, irq}, 32'h1);
      wr(8'h24, 32'h1F);
      rdc(8'h1C, 32'h0);
    end
    wr(8'h20, 32'h0);
    wr(8'h0C, 32'h01);
    cmp({31'h0, irq}, 32'h0);
    wr(8'h24, 32'h1F);
    wr(8'h20, 32'h1F);
    host(16'h002D, 1'b0);
    wr(8'h0C, 32'h06);
    rdc(8'h1C, 32'h10);
    wr(8'h24, 32'h1F);
    wr(8'h0C, 32'h05);
    rdc(8'h10, 32'h0D);
    cmp({31'h0, processing}, 32'h1);
    for (int k = 0; k < 3000 && processing !== 1'b0; k++) @(posedge core_clk);
    rdc(8'h08, 32'h03);
    rdc(8'h1C, 32'h01);
    rdc(8'h10, 32'h0E);
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, tq_gw[i]);
      rdc(8'h04, tq_gr[i]);
      host(tq_ref[i], 1'b1);
      cmp({16'h0, torque_cmd}, {16'h0, tq_exp[i]});
    end
    slow <= 1'b0;
    wr(8'h0C, 32'h14);
    rdc(8'h04, 32'h1E);
    rdc(8'h08, 32'h03);
    wr(8'h08, 32'h80);
    rdc(8'h08, 32'hFFFFFF81);
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h10);
    rdc(8'h08, 32'hFFFFFF81);
    wr(8'h0C, 32'h04);
    wr(8'h08, 32'h7F);
    rdc(8'h08, 32'h7F);
    wr(8'h24, 32'h1F);
    host(16'h3075, 1'b1);
    cmp({16'h0, torque_cmd}, 32'h0DAC);
    rdc(8'h18, 32'h0DAC);
    rdc(8'h14, 32'h3075);
    rdc(8'h1C, 32'h0C);
    cmp({31'h0, irq}, 32'h1);
    host(16'h0771, 1'b1);
    cmp({16'h0, torque_cmd}, 32'h0);
    wr(8'h24, 32'h1F);
    rdc(8'h1C, 32'h0);
    host(16'h3075, 1'b0);
    cmp({16'h0, torque_cmd}, 32'h0);
    cmp({31'h0, power_blocked_state}, 32'h1);
    test_done();
  end
endmodule // test_trs_top
